// ===== bench/cal_alu_assertions.sv
// Purpose : Port-level checks on the integer datapath
// Assumes : Status is never written over the port during an operation
// Notes   : Bound to cal_alu below
`timescale 1ns/1ps
module cal_alu_assertions (
	input wire logic                i_clk,
	input wire logic                i_reset_n,
	input wire logic                i_op_valid,
	input wire cal_pkg::cal_op_s    i_op,
	input wire logic                i_div_hold,
	input wire logic                i_reg_wr,
	input wire logic                o_op_ready,
	input wire cal_pkg::cal_memwr_s o_mem_wr,
	input wire logic                o_fault,
	input wire logic [15:0]         o_status
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	logic       take;
	logic       shf;
	logic [5:0] busy_cnt;
	logic [5:0] hold_cnt;
	// Issue and shift decode
	assign take = i_op_valid && o_op_ready;
	assign shf  = i_op.opc inside {cal_pkg::CAL_OP_ARITH_RIGHT_SHIFT, cal_pkg::CAL_OP_LEFT_SHIFT,
		cal_pkg::CAL_OP_LOGIC_RIGHT_SHIFT};
	// Busy and held cycles; cleared when ready so each divide is judged alone
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			busy_cnt <= 6'h00;
			hold_cnt <= 6'h00;
		end else begin
			busy_cnt <= o_op_ready ? 6'h00 : busy_cnt + 6'h01;
			hold_cnt <= o_op_ready ? 6'h00 : hold_cnt + {5'h00, i_div_hold};
		end
	end
	chk_status_unused: assert property (o_status[15:9] == 7'h00 && o_status[7:4] == 4'h0)
		else $error("status reserved bits set");
	chk_div_busy: assert property (take && i_op.opc == cal_pkg::CAL_OP_DIV
		|=> (!o_op_ready)[*8])
		else $error("ready during divide");
	chk_div_cycles: assert property ($rose(o_op_ready) |-> busy_cnt - hold_cnt == 6'h12)
		else $error("divide length wrong");
	chk_shift_fault: assert property (take && shf && (i_op.src_mem || i_op.dst_mem)
		|=> o_fault && !o_mem_wr.wr)
		else $error("memory shift not refused");
	chk_fault_cause: assert property (o_fault |->
		$past(take && shf && (i_op.src_mem || i_op.dst_mem)))
		else $error("fault without cause");
	chk_mem_write: assert property (take && i_op.dst_mem &&
		i_op.opc <= cal_pkg::CAL_OP_XOR |=> o_mem_wr.wr &&
		o_mem_wr.addr == $past(i_op.mem_addr))
		else $error("memory result not written");
	chk_no_stray_wr: assert property (!take |=> !o_mem_wr.wr)
		else $error("memory write without issue");
	chk_byte_upper: assert property (take && i_op.dst_mem && i_op.byte_mode
		|=> o_mem_wr.data[15:8] == 8'h00)
		else $error("byte write upper lane set");
	chk_mul_flags: assert property (take && i_op.opc == cal_pkg::CAL_OP_MUL && !i_reg_wr
		|=> $stable(o_status))
		else $error("multiply changed flags");
	chk_div_flags: assert property (!o_op_ready && !i_reg_wr |=> $stable(o_status))
		else $error("divide changed flags");
endmodule : cal_alu_assertions

bind cal_alu cal_alu_assertions u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_op_valid(i_op_valid), .i_op(i_op), .i_div_hold(i_div_hold), .i_reg_wr(i_reg_wr),
	.o_op_ready(o_op_ready), .o_mem_wr(o_mem_wr), .o_fault(o_fault), .o_status(o_status));

// ===== bench/cal_alu_test.sv
// Purpose : Self-checking bench for the integer datapath
// Assumes : Register port map 0..15 working, status at the status address
// Notes   : Operations are issued one at a time through tasks
`timescale 1ns/1ps
`include "cal_params.svh"
module cal_alu_test;
	logic clk, rst_n, valid, hold, wr, rd, ready, fault;
	logic [4:0] addr;
	logic [15:0] wdata, mrd, rdata, status, v;
	cal_pkg::cal_op_s op;
	cal_pkg::cal_memwr_s mwr;
	int error_cnt, check_count;
	cal_pkg::cal_mul_mode_e mm [6] = '{cal_pkg::CAL_MUL_SS, cal_pkg::CAL_MUL_UU,
		cal_pkg::CAL_MUL_US, cal_pkg::CAL_MUL_SU, cal_pkg::CAL_MUL_S_LIT, cal_pkg::CAL_MUL_U_LIT};
	logic [15:0] mhi [6] = '{16'h0000, 16'hfffb, 16'hfffd, 16'hfffe, 16'hffff, 16'h0002};
	cal_pkg::cal_op_s t;
	cal_pkg::cal_opc_e so [3] = '{cal_pkg::CAL_OP_ARITH_RIGHT_SHIFT, cal_pkg::CAL_OP_LEFT_SHIFT,
		cal_pkg::CAL_OP_LOGIC_RIGHT_SHIFT};
	logic [15:0] sx [3] = '{16'hf800, 16'h0010, 16'h0800};
	cal_alu uut (.i_clk(clk), .i_reset_n(rst_n), .i_op_valid(valid), .i_op(op), .i_div_hold(hold),
		.i_mem_rdata(mrd), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_op_ready(ready), .o_mem_wr(mwr), .o_fault(fault), .o_status(status), .o_reg_rdata(rdata));
	cal_mem_model u_mem (.i_clk(clk), .i_wr(mwr), .i_addr(op.mem_addr), .o_rdata(mrd));
	// Free-running 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic tally_and_finish;
		if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr
	// Read data stand only in the cycle after the read strobe
	task automatic chk(input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, exp);
	endtask : chk
	task automatic issue(input cal_pkg::cal_op_s o);
		@(posedge clk);
		valid <= 1'b1;
		op <= o;
		@(posedge clk);
		valid <= 1'b0;
		#1;
	endtask : issue
	function automatic cal_pkg::cal_op_s mk(input cal_pkg::cal_opc_e c, input logic [3:0] a,
		input logic [3:0] b, input logic [3:0] d);
		mk = '0;
		mk.opc = c;
		mk.src_a = a;
		mk.src_b = b;
		mk.dst = d;
	endfunction : mk
	// Bounded wait for ready; held cycles are placed from the fifth busy cycle on
	task automatic div_run(input cal_pkg::cal_op_s o, input int nh, input logic [15:0] q, r);
		int n;
		issue(o);
		n = 1;
		while (ready !== 1'b1 && n < 60) begin
			@(posedge clk);
			n++;
			hold <= (n >= 5 && n < 5 + nh);
			#1;
		end
		if (n >= 60) begin
			error_cnt++;
			tally_and_finish();
		end
		check(16'(n), 16'(19 + nh));
		chk(5'h00, q);
		chk(5'h01, r);
	endtask : div_run
	initial begin
		rst_n = 1'b0;
		valid = 1'b0;
		hold = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		op = '0;
		addr = 5'h00;
		wdata = 16'h0000;
		error_cnt = 0;
		check_count = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		chk(`CAL_ADDR_SR, 16'h0000);
		reg_wr(5'h02, 16'h7fff);
		reg_wr(5'h03, 16'h0001);
		issue(mk(cal_pkg::CAL_OP_ADD, 4'h2, 4'h3, 4'h4));
		chk(5'h04, 16'h8000);
		chk(`CAL_ADDR_SR, 16'h010c);
		issue(mk(cal_pkg::CAL_OP_SUB, 4'h3, 4'h3, 4'h4));
		chk(`CAL_ADDR_SR, 16'h0103);
		issue(mk(cal_pkg::CAL_OP_SUBB, 4'h3, 4'h3, 4'h4));
		chk(`CAL_ADDR_SR, 16'h0103);
		issue(mk(cal_pkg::CAL_OP_ADDC, 4'h3, 4'h3, 4'h4));
		chk(`CAL_ADDR_SR, 16'h0000);
		// A chained zero result must not set a zero flag that is clear
		t = mk(cal_pkg::CAL_OP_SUBB, 4'h4, 4'h0, 4'h4);
		t.use_lit = 1'b1;
		t.lit = 5'h02;
		issue(t);
		chk(`CAL_ADDR_SR, 16'h0101);
		t = mk(cal_pkg::CAL_OP_ADD, 4'h2, 4'h3, 4'h0);
		t.byte_mode = 1'b1;
		t.dst_mem = 1'b1;
		t.mem_addr = 16'h0006;
		issue(t);
		chk(`CAL_ADDR_SR, 16'h0103);
		check(status, 16'h0103);
		check(u_mem.mem[3], 16'h0300);
		t = mk(cal_pkg::CAL_OP_ADD, 4'h0, 4'h3, 4'hc);
		t.src_mem = 1'b1;
		t.mem_addr = 16'h0002;
		issue(t);
		chk(5'h0c, 16'h0110);
		reg_wr(5'h05, 16'h8001);
		// One pass per shift kind, four places each
		for (int i = 0; i < 3; i++) begin
			t = mk(so[i], 4'h5, 4'h0, 4'h6);
			t.use_lit = 1'b1;
			t.lit = 5'h04;
			issue(t);
			chk(5'h06, sx[i]);
		end
		t.opc = cal_pkg::CAL_OP_LEFT_SHIFT;
		t.src_mem = 1'b1;
		issue(t);
		check({15'h0000, fault}, 16'h0001);
		chk(5'h06, 16'h0800);
		// Widest shift still lands in one cycle
		t.opc = cal_pkg::CAL_OP_ARITH_RIGHT_SHIFT;
		t.src_mem = 1'b0;
		t.lit = 5'h0f;
		issue(t);
		chk(5'h06, 16'hffff);
		reg_wr(5'h06, 16'hfffe);
		reg_wr(5'h07, 16'hfffd);
		// Minus two times minus three per sign mode, literal modes times three
		for (int i = 0; i < 6; i++) begin
			t = mk(cal_pkg::CAL_OP_MUL, 4'h6, 4'h7, 4'h8);
			t.use_lit = (i >= 4);
			t.lit = 5'h03;
			t.mul_mode = mm[i];
			issue(t);
			chk(5'h08, (i >= 4) ? 16'hfffa : 16'h0006);
			chk(5'h09, mhi[i]);
		end
		t.mul_mode = cal_pkg::CAL_MUL_BYTE;
		t.byte_mode = 1'b1;
		issue(t);
		chk(5'h08, 16'h02fa);
		reg_wr(5'h0a, 16'hfff9);
		reg_wr(5'h0b, 16'h0002);
		t = mk(cal_pkg::CAL_OP_DIV, 4'ha, 4'hb, 4'h0);
		t.div_signed = 1'b1;
		div_run(t, 0, 16'hfffd, 16'hffff);
		reg_wr(5'h02, 16'h0000);
		t = mk(cal_pkg::CAL_OP_DIV, 4'h2, 4'hb, 4'h0);
		t.div_long = 1'b1;
		div_run(t, 3, 16'h8000, 16'h0000);
		tally_and_finish();
	end
endmodule : cal_alu_test

// ===== bench/cal_mem_model.sv
// Purpose : Data memory on the far side of the datapath
// Assumes : Sixteen words, word index from address bits 4:1
// Notes   : Preset word holds its index in the upper byte and 0x0f below
`timescale 1ns/1ps
module cal_mem_model (
	input  wire logic               i_clk,
	input  wire cal_pkg::cal_memwr_s i_wr,
	input  wire logic [15:0]        i_addr,
	output logic      [15:0]        o_rdata
);
	logic [15:0] mem [16];
	// operand read
	// Combinational read, the datapath samples it in the issue cycle
	assign o_rdata = mem[i_addr[4:1]];
	// byte lane
	// Byte writes touch only the low lane, as the real array would
	always @(posedge i_clk) begin
		if (i_wr.wr && i_wr.byte_mode) mem[i_wr.addr[4:1]][7:0] <= i_wr.data[7:0];
		else if (i_wr.wr) mem[i_wr.addr[4:1]] <= i_wr.data;
	end
	// A non-zero low lane shows whether a byte write of zero really landed
	initial for (int i = 0; i < 16; i++) mem[i] = {i[7:0], 8'h0f};
endmodule : cal_mem_model

// ===== verilog/cal_alu.sv
// Purpose : 16-bit CPU integer datapath: ALU with flags, multiplier, divider, shifter
// Assumes : Decoder issues one operation per cycle while o_op_ready is high
// Notes   : Holds the working-register array and the ALU status register
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "cal_params.svh"
module cal_alu #(
	parameter int NUM_WREG = 16
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_reset_n,
	input  wire logic                   i_op_valid,
	input  wire cal_pkg::cal_op_s       i_op,
	input  wire logic                   i_div_hold,
	input  wire logic [15:0]            i_mem_rdata,
	input  wire logic [`CAL_ADDR_W-1:0] i_reg_addr,
	input  wire logic [15:0]            i_reg_wdata,
	input  wire logic                   i_reg_wr,
	input  wire logic                   i_reg_rd,
	output logic                        o_op_ready,
	output cal_pkg::cal_memwr_s         o_mem_wr,
	output logic                        o_fault,
	output logic      [15:0]            o_status,
	output logic      [15:0]            o_reg_rdata
);

	logic [15:0]         wreg      [0:NUM_WREG-1];
	logic [15:0]         next_wreg [0:NUM_WREG-1];
	logic [15:0]         sr, next_sr;
	cal_pkg::cal_memwr_s mem_wr, next_mem_wr;
	logic                fault, next_fault;
	logic [15:0]         rdata, next_rdata;

	logic                accept;
	logic                div_busy;
	logic                div_done;
	logic                div_start;
	logic [15:0]         div_quot;
	logic [15:0]         div_rem;
	logic [31:0]         product;
	logic [3:0]          pair_lo;
	logic [3:0]          pair_hi;
	logic [15:0]         a_val;
	logic [15:0]         b_val;

	// ------------------------------------------------------------------------
	// Operand selection
	// ------------------------------------------------------------------------
	// register or memory operand
	assign a_val     = i_op.src_mem ? i_mem_rdata : wreg[i_op.src_a];
	assign b_val     = i_op.use_lit ? {11'h000, i_op.lit} : wreg[i_op.src_b];
	assign pair_lo   = {i_op.src_a[3:1], 1'b0};
	assign pair_hi   = {i_op.src_a[3:1], 1'b1};
	assign accept    = i_op_valid && !div_busy;
	assign div_start = accept && (i_op.opc == cal_pkg::CAL_OP_DIV);

	// ------------------------------------------------------------------------
	// Multiplier and divider
	// ------------------------------------------------------------------------
	cal_mul u_mul (
		.i_a       (a_val),
		.i_b       (b_val),
		.i_lit     (i_op.lit),
		.i_mode    (i_op.mul_mode),
		.o_product (product)
	);

	cal_div u_div (
		.i_clk         (i_clk),
		.i_reset_n     (i_reset_n),
		.i_start       (div_start),
		.i_hold        (i_div_hold),
		.i_signed      (i_op.div_signed),
		.i_long        (i_op.div_long),
		.i_dividend_hi (wreg[pair_hi]),
		.i_dividend_lo (i_op.div_long ? wreg[pair_lo] : wreg[i_op.src_a]),
		.i_divisor     (wreg[i_op.src_b]),
		.o_busy        (div_busy),
		.o_done        (div_done),
		.o_quot        (div_quot),
		.o_rem         (div_rem)
	);

	// ------------------------------------------------------------------------
	// Arithmetic, logic and shift datapath with flags
	// ------------------------------------------------------------------------
	logic [15:0] b_eff;
	logic        cin;
	logic        is_arith;
	logic        is_sub;
	logic        is_chain;
	logic        is_shift;
	logic [16:0] sum_w;
	logic [8:0]  sum_b;
	logic [4:0]  sum_n;
	logic [15:0] res;
	logic        flag_c;
	logic        flag_dc;
	logic        flag_ov;
	logic        msb_a;
	logic        msb_b;
	logic        msb_r;
	logic        res_zero;
	logic [3:0]  sh;
	logic [16:0] sh_src;
	logic [16:0] sh_out;
	logic        writes_c;

	always_comb begin
		is_sub   = (i_op.opc == cal_pkg::CAL_OP_SUB) || (i_op.opc == cal_pkg::CAL_OP_SUBB);
		is_chain = (i_op.opc == cal_pkg::CAL_OP_ADDC) || (i_op.opc == cal_pkg::CAL_OP_SUBB);
		is_arith = (i_op.opc == cal_pkg::CAL_OP_ADD) || (i_op.opc == cal_pkg::CAL_OP_ADDC) ||
		           is_sub;
		is_shift = (i_op.opc == cal_pkg::CAL_OP_ARITH_RIGHT_SHIFT) ||
		           (i_op.opc == cal_pkg::CAL_OP_LEFT_SHIFT) ||
		           (i_op.opc == cal_pkg::CAL_OP_LOGIC_RIGHT_SHIFT);
		b_eff    = is_sub ? ~b_val : b_val;
		cin      = is_chain ? sr[`CAL_SR_C_BIT] : is_sub;
		sum_w    = {1'b0, a_val} + {1'b0, b_eff} + {16'h0000, cin};
		sum_b    = {1'b0, a_val[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
		sum_n    = {1'b0, a_val[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
		flag_dc  = i_op.byte_mode ? sum_n[4] : sum_b[8];
		flag_c   = i_op.byte_mode ? sum_b[8] : sum_w[16];
		msb_a    = i_op.byte_mode ? a_val[7] : a_val[15];
		msb_b    = i_op.byte_mode ? b_eff[7] : b_eff[15];
		// barrel shift, 17 bits keep the last bit out
		sh       = b_val[3:0];
		sh_src   = 17'h00000;
		sh_out   = 17'h00000;
		writes_c = is_arith;
		res      = sum_w[15:0];
		case (i_op.opc)
			cal_pkg::CAL_OP_AND: begin
				res = a_val & b_val;
			end
			cal_pkg::CAL_OP_OR: begin
				res = a_val | b_val;
			end
			cal_pkg::CAL_OP_XOR: begin
				res = a_val ^ b_val;
			end
			cal_pkg::CAL_OP_LEFT_SHIFT: begin
				sh_src = {1'b0, a_val};
				sh_out = sh_src << sh;
				res    = sh_out[15:0];
				flag_c = i_op.byte_mode ? sh_out[8] : sh_out[16];
			end
			cal_pkg::CAL_OP_ARITH_RIGHT_SHIFT: begin
				sh_src = i_op.byte_mode ? {{8{a_val[7]}}, a_val[7:0], 1'b0} : {a_val, 1'b0};
				sh_out = 17'($signed(sh_src) >>> sh);
				res    = sh_out[16:1];
				flag_c = sh_out[0];
			end
			cal_pkg::CAL_OP_LOGIC_RIGHT_SHIFT: begin
				sh_src = i_op.byte_mode ? {8'h00, a_val[7:0], 1'b0} : {a_val, 1'b0};
				sh_out = sh_src >> sh;
				res    = sh_out[16:1];
				flag_c = sh_out[0];
			end
			default: begin
				res = sum_w[15:0];
			end
		endcase
		if (is_shift) begin
			writes_c = (sh != 4'h0);
		end
		msb_r    = i_op.byte_mode ? res[7] : res[15];
		res_zero = i_op.byte_mode ? (res[7:0] == 8'h00) : (res == 16'h0000);
		flag_ov  = is_arith && (msb_a == msb_b) && (msb_r != msb_a);
	end

	// ------------------------------------------------------------------------
	// Working registers, status, memory write and register port
	// ------------------------------------------------------------------------
	// Datapath writes are applied after port writes, so the datapath wins a clash
	always_comb begin
		for (int i = 0; i < NUM_WREG; i++) begin
			next_wreg[i] = wreg[i];
		end
		next_sr     = sr;
		next_mem_wr = '0;
		next_fault  = 1'b0;
		next_rdata  = 16'h0000;
		if (i_reg_rd) begin
			if (i_reg_addr == `CAL_ADDR_SR) begin
				next_rdata = sr;
			end else if (i_reg_addr < `CAL_ADDR_W'(NUM_WREG)) begin
				next_rdata = wreg[i_reg_addr[3:0]];
			end
		end
		if (i_reg_wr) begin
			if (i_reg_addr == `CAL_ADDR_SR) begin
				next_sr = i_reg_wdata & `CAL_SR_WMASK;
			end else if (i_reg_addr < `CAL_ADDR_W'(NUM_WREG)) begin
				next_wreg[i_reg_addr[3:0]] = i_reg_wdata;
			end
		end
		if (accept && (is_arith || is_shift || (i_op.opc == cal_pkg::CAL_OP_AND) ||
		    (i_op.opc == cal_pkg::CAL_OP_OR) || (i_op.opc == cal_pkg::CAL_OP_XOR))) begin
			if (is_shift && (i_op.src_mem || i_op.dst_mem)) begin
				next_fault = 1'b1;
			end else begin
				next_sr[`CAL_SR_N_BIT] = msb_r;
				next_sr[`CAL_SR_Z_BIT] = is_chain ? (sr[`CAL_SR_Z_BIT] && res_zero) : res_zero;
				if (is_arith) begin
					next_sr[`CAL_SR_OV_BIT] = flag_ov;
					next_sr[`CAL_SR_DC_BIT] = flag_dc;
				end
				if (writes_c) begin
					next_sr[`CAL_SR_C_BIT] = flag_c;
				end
				// byte writes keep the upper byte
				if (i_op.dst_mem) begin
					next_mem_wr.wr        = 1'b1;
					next_mem_wr.byte_mode = i_op.byte_mode;
					next_mem_wr.addr      = i_op.mem_addr;
					next_mem_wr.data      = i_op.byte_mode ? {8'h00, res[7:0]} : res;
				end else begin
					next_wreg[i_op.dst] = i_op.byte_mode ? {wreg[i_op.dst][15:8], res[7:0]} : res;
				end
			end
		end
		if (accept && (i_op.opc == cal_pkg::CAL_OP_MUL)) begin
			if (i_op.mul_mode == cal_pkg::CAL_MUL_BYTE) begin
				next_wreg[i_op.dst] = product[15:0];
			end else begin
				next_wreg[{i_op.dst[3:1], 1'b0}] = product[15:0];
				next_wreg[{i_op.dst[3:1], 1'b1}] = product[31:16];
			end
		end
		if (div_done) begin
			next_wreg[0] = div_quot;
			next_wreg[1] = div_rem;
		end
	end

	// One flip-flop stage per working register
	generate
		for (genvar g = 0; g < NUM_WREG; g++) begin : g_wreg
			always_ff @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					wreg[g] <= `CAL_WREG_RESET;
				end else begin
					wreg[g] <= next_wreg[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sr     <= `CAL_SR_RESET;
			mem_wr <= '0;
			fault  <= 1'b0;
			rdata  <= 16'h0000;
		end else begin
			sr     <= next_sr;
			mem_wr <= next_mem_wr;
			fault  <= next_fault;
			rdata  <= next_rdata;
		end
	end

	// Divider occupancy stalls the decoder; nothing is queued behind it
	assign o_op_ready  = !div_busy;
	assign o_mem_wr    = mem_wr;
	assign o_fault     = fault;
	assign o_status    = sr;
	assign o_reg_rdata = rdata;

endmodule : cal_alu

// ===== verilog/cal_div.sv
// Purpose : Iterative 32/16 and 16/16 divider, one quotient bit per cycle
// Assumes : Start only while idle; hold freezes the sequence at any cycle
// Notes   : Divide by zero and quotient overflow give undefined results
`timescale 1ns/1ps
`include "cal_params.svh"
module cal_div (
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_start,
	input  wire logic        i_hold,
	input  wire logic        i_signed,
	input  wire logic        i_long,
	input  wire logic [15:0] i_dividend_hi,
	input  wire logic [15:0] i_dividend_lo,
	input  wire logic [15:0] i_divisor,
	output logic             o_busy,
	output logic             o_done,
	output logic      [15:0] o_quot,
	output logic      [15:0] o_rem
);

	cal_pkg::cal_div_state_e state, next_state;
	logic [31:0]                dvd, next_dvd;
	logic [15:0]                dvs, next_dvs;
	logic [15:0]                rem, next_rem;
	logic [15:0]                dq, next_dq;
	logic                       sgn, next_sgn;
	logic                       neg_d, next_neg_d;
	logic                       neg_q, next_neg_q;
	logic [`CAL_DIV_CNT_W-1:0]  cnt, next_cnt;
	logic [31:0]                mag;
	logic [16:0]                trial;
	logic [16:0]                diff;
	logic                       ge;
	logic [15:0]                step_rem;
	logic [15:0]                step_q;

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	// Magnitudes are divided and signs restored on the last step, so the
	// whole sequence costs issue + load + 16 steps + result cycle
	always_comb begin
		next_state = state;
		next_dvd   = dvd;
		next_dvs   = dvs;
		next_rem   = rem;
		next_dq    = dq;
		next_sgn   = sgn;
		next_neg_d = neg_d;
		next_neg_q = neg_q;
		next_cnt   = cnt;
		mag        = (sgn && dvd[31]) ? (32'h0 - dvd) : dvd;
		trial      = {rem, dq[15]};
		diff       = trial - {1'b0, dvs};
		ge         = (trial >= {1'b0, dvs});
		step_rem   = ge ? diff[15:0] : trial[15:0];
		step_q     = {dq[14:0], ge};
		case (state)
			cal_pkg::CAL_DIV_IDLE: begin
				if (i_start) begin
					next_dvd   = i_long ? {i_dividend_hi, i_dividend_lo} :
					             {(i_signed ? {16{i_dividend_lo[15]}} : 16'h0000),
					              i_dividend_lo};
					next_dvs   = i_divisor;
					next_sgn   = i_signed;
					next_state = cal_pkg::CAL_DIV_LOAD;
				end
			end
			cal_pkg::CAL_DIV_LOAD: begin
				if (!i_hold) begin
					next_neg_d = sgn && dvd[31];
					next_neg_q = sgn && (dvd[31] ^ dvs[15]);
					next_dvs   = (sgn && dvs[15]) ? (16'h0000 - dvs) : dvs;
					next_rem   = mag[31:16];
					next_dq    = mag[15:0];
					next_cnt   = '0;
					next_state = cal_pkg::CAL_DIV_ITER;
				end
			end
			cal_pkg::CAL_DIV_ITER: begin
				if (!i_hold) begin
					next_rem = step_rem;
					next_dq  = step_q;
					next_cnt = cnt + 1'b1;
					if (cnt == `CAL_DIV_LAST) begin
						next_dq    = neg_q ? (16'h0000 - step_q) : step_q;
						next_rem   = neg_d ? (16'h0000 - step_rem) : step_rem;
						next_state = cal_pkg::CAL_DIV_FIX;
					end
				end
			end
			cal_pkg::CAL_DIV_FIX: begin
				if (!i_hold) begin
					next_state = cal_pkg::CAL_DIV_IDLE;
				end
			end
			default: begin
				next_state = cal_pkg::CAL_DIV_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= cal_pkg::CAL_DIV_IDLE;
			dvd   <= 32'h0000_0000;
			dvs   <= 16'h0000;
			rem   <= 16'h0000;
			dq    <= 16'h0000;
			sgn   <= 1'b0;
			neg_d <= 1'b0;
			neg_q <= 1'b0;
			cnt   <= '0;
		end else begin
			state <= next_state;
			dvd   <= next_dvd;
			dvs   <= next_dvs;
			rem   <= next_rem;
			dq    <= next_dq;
			sgn   <= next_sgn;
			neg_d <= next_neg_d;
			neg_q <= next_neg_q;
			cnt   <= next_cnt;
		end
	end

	// Results sit in flip-flops; done marks the single write-back cycle
	assign o_busy = (state != cal_pkg::CAL_DIV_IDLE);
	assign o_done = (state == cal_pkg::CAL_DIV_FIX) && !i_hold;
	assign o_quot = dq;
	assign o_rem  = rem;

endmodule : cal_div

// ===== verilog/cal_mul.sv
// Purpose : Single-cycle 17x17 multiplier with operand sign and size modes
// Assumes : Combinational; the caller registers the product
// Notes   : Byte mode leaves the upper product half zero
`timescale 1ns/1ps
module cal_mul (
	input  wire logic [15:0]           i_a,
	input  wire logic [15:0]           i_b,
	input  wire logic [4:0]            i_lit,
	input  wire cal_pkg::cal_mul_mode_e i_mode,
	output logic      [31:0]           o_product
);

	logic signed [16:0] op_a;
	logic signed [16:0] op_b;
	logic signed [33:0] full;

	// ------------------------------------------------------------------------
	// Operand extension
	// ------------------------------------------------------------------------
	// Every mode maps onto one signed 17x17 product, so one array serves all
	always_comb begin
		op_a = {1'b0, i_a};
		op_b = {1'b0, i_b};
		case (i_mode)
			cal_pkg::CAL_MUL_SS: begin
				op_a = {i_a[15], i_a};
				op_b = {i_b[15], i_b};
			end
			cal_pkg::CAL_MUL_US: begin
				op_b = {i_b[15], i_b};
			end
			cal_pkg::CAL_MUL_SU: begin
				op_a = {i_a[15], i_a};
			end
			cal_pkg::CAL_MUL_S_LIT: begin
				op_a = {i_a[15], i_a};
				op_b = {12'h000, i_lit};
			end
			cal_pkg::CAL_MUL_U_LIT: begin
				op_b = {12'h000, i_lit};
			end
			cal_pkg::CAL_MUL_BYTE: begin
				op_a = {9'h000, i_a[7:0]};
				op_b = {9'h000, i_b[7:0]};
			end
			default: begin
				op_a = {1'b0, i_a};
			end
		endcase
	end

	assign full      = op_a * op_b;
	assign o_product = full[31:0];

endmodule : cal_mul

// ===== verilog/cal_params.svh
// Purpose : Constants of the CPU integer datapath (flag positions, reset values, counts)
// Assumes : Included by bare name from cal_alu, cal_div and the test bench
// Notes   : Definitions only
`ifndef CAL_PARAMS_SVH
`define CAL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Status register layout
// ----------------------------------------------------------------------------
`define CAL_SR_C_BIT      0
`define CAL_SR_Z_BIT      1
`define CAL_SR_OV_BIT     2
`define CAL_SR_N_BIT      3
`define CAL_SR_DC_BIT     8
`define CAL_SR_RESET      16'h0000
`define CAL_SR_WMASK      16'h010f

// ----------------------------------------------------------------------------
// Register port map
// ----------------------------------------------------------------------------
`define CAL_ADDR_W        5
`define CAL_ADDR_SR       5'h10
`define CAL_WREG_RESET    16'h0000

// ----------------------------------------------------------------------------
// Divider timing
// ----------------------------------------------------------------------------
`define CAL_DIV_CYCLES    19
`define CAL_DIV_ITERS     16
`define CAL_DIV_CNT_W     4
`define CAL_DIV_LAST      4'hf

`endif

// ===== verilog/cal_pkg.sv
// Purpose : Types shared by the CPU integer datapath modules
// Assumes : Constants live in cal_params.svh
// Notes   : No imports; users write cal_pkg::name
package cal_pkg;

	// ------------------------------------------------------------------------
	// Operations issued by the decoder
	// ------------------------------------------------------------------------
	typedef enum logic [3:0] {
		CAL_OP_ADD,
		CAL_OP_ADDC,
		CAL_OP_SUB,
		CAL_OP_SUBB,
		CAL_OP_AND,
		CAL_OP_OR,
		CAL_OP_XOR,
		CAL_OP_ARITH_RIGHT_SHIFT,
		CAL_OP_LEFT_SHIFT,
		CAL_OP_LOGIC_RIGHT_SHIFT,
		CAL_OP_MUL,
		CAL_OP_DIV
	} cal_opc_e;

	// Multiplier sign and size modes
	typedef enum logic [2:0] {
		CAL_MUL_SS,
		CAL_MUL_UU,
		CAL_MUL_US,
		CAL_MUL_SU,
		CAL_MUL_S_LIT,
		CAL_MUL_U_LIT,
		CAL_MUL_BYTE
	} cal_mul_mode_e;

	// Divider sequence
	typedef enum logic [1:0] {
		CAL_DIV_IDLE,
		CAL_DIV_LOAD,
		CAL_DIV_ITER,
		CAL_DIV_FIX
	} cal_div_state_e;

	// ------------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------------
	typedef struct packed {
		cal_opc_e      opc;
		logic          byte_mode;
		logic          src_mem;
		logic          dst_mem;
		logic [3:0]    src_a;
		logic [3:0]    src_b;
		logic [3:0]    dst;
		logic          use_lit;
		logic [4:0]    lit;
		cal_mul_mode_e mul_mode;
		logic          div_signed;
		logic          div_long;
		logic [15:0]   mem_addr;
	} cal_op_s;

	typedef struct packed {
		logic        wr;
		logic        byte_mode;
		logic [15:0] addr;
		logic [15:0] data;
	} cal_memwr_s;

endpackage : cal_pkg
